//--- rx_mask_params.svh
`ifndef RX_MASK_PARAMS_SVH
`define RX_MASK_PARAMS_SVH
`define OFS_MASK_THREE 12'h0a2
`define OFS_MASK_FOUR 12'h0a3
`define OFS_MASK_HDLC 12'h0a4
`define OFS_MASK_LINK 12'h0a6
`define OFS_SIG_EN_1 12'h0a8
`define OFS_SIG_EN_2 12'h0a9
`define OFS_SIG_EN_3 12'h0aa
`define OFS_SIG_EN_4 12'h0ab
`define OFS_UP_1 12'h0ac
`define OFS_UP_2 12'h0ad
`define OFS_DN_1 12'h0ae
`define OFS_DN_2 12'h0af
`define OFS_SA_POS_MASK 12'h0bc
`define OFS_STATUS 12'h0bd
`define OFS_CTRL 12'h0be
`define PORT_STRIDE 12'h200
`define MASK_THREE_E1_BITS 8'h3b
`define MASK_FOUR_BITS 8'hef
`define MASK_HDLC_BITS 8'h3f
`define MASK_LINK_T1_BITS 8'h3f
`define MASK_LINK_E1_BITS 8'h03
`define BIT_SIG_CHANGE 3
`define REG_RESET 8'h00
`endif

//--- rx_mask_pkg.sv
package rx_mask_pkg;
  typedef struct packed {
    logic [7:0] mask_three;
    logic [7:0] mask_four;
    logic [7:0] mask_hdlc;
    logic [7:0] mask_link;
    logic [31:0] sig_en;
    logic [7:0] up_1;
    logic [7:0] up_2;
    logic [7:0] dn_1;
    logic [7:0] dn_2;
    logic [7:0] sa_pos_mask;
    logic [7:0] status_four;
    logic [7:0] stat_other;
    logic [7:0] sa_prev;
    logic up_restart;
    logic dn_restart;
    logic [31:0] prdata;
  } regs_t;
  typedef struct packed {
    logic [7:0] three;
    logic [7:0] four;
    logic [7:0] hdlc;
    logic [7:0] link;
  } events_t;
endpackage

//--- rx_mask_regs.sv
`timescale 1ns/1ps
`include "rx_mask_params.svh"
// Behaviour
// - E1 mask three: bits 5,4 clear, 3 clock loss, 1,0 detect enables.
// - Mask four at 0A3h enables elastic, slip, signaling, tick, timer, multiframe.
// - Mask five at 0A4h gates six receive HDLC interrupts; bits 7,6 unused.
// - T1 mask seven at 0A6h enables CI alarms, carrier frame, link, code events.
// - E1 mask seven: bit 1 Sa6 codeword, bit 0 Sa change; rest unused.
// - Sa change raised only for positions left unmasked by position mask.
// - Four channel enable registers at 0A8h..0ABh, channel 1..32, fourth E1 only.
// - Enabled channel signaling change sets latched status four bit 3.
// - T1 up code pattern in 0ACh, 0ADh; bit 7 first; reset zero.
// - Pattern bits beyond selected length are ignored by the detector.
// - T1 down code pattern in 0AEh, 0AFh with same don't-care handling.
// - Writing first up or down pattern register restarts its integration.
// - Interrupt mask bit one enables, zero blocks; all masks reset to zero.
// - Up and down present flags follow matching received code.
// - Source summary omits masked bits; clears when no unmasked event left.
module rx_mask_regs #(
  parameter int PORT_INDEX = 0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer mode and event sources
  input wire logic e1_mode,
  input wire rx_mask_pkg::events_t events,
  input wire logic [31:0] sig_change,
  input wire logic [7:0] sa_bits,
  input wire logic up_match,
  input wire logic dn_match,
  // Detector controls and interrupt summary
  output logic [7:0] up_pattern,
  output logic [7:0] dn_pattern,
  output logic up_restart,
  output logic dn_restart,
  output logic up_code_present,
  output logic down_code_present,
  output logic [7:0] latched_status_four,
  output logic [3:0] rx_interrupt_source_summary,
  output logic rx_int
);
  initial begin
    if (PORT_INDEX < 0 || PORT_INDEX > 7) begin
      $error("PORT_INDEX out of range");
    end
  end

  localparam logic [11:0] BASE = 12'(PORT_INDEX) * `PORT_STRIDE;

  // Printed offsets are word indices, so the byte address is four times the index
  function automatic logic hit(input logic [13:0] a, input logic [11:0] ofs);
    hit = (a[13:2] == BASE + ofs) && (a[1:0] == 2'b00);
  endfunction

  rx_mask_pkg::regs_t r_r, r_nxt;
  logic wr_en, rd_en, mapped;
  logic [7:0] wb;
  logic [7:0] three_valid, link_valid, sa_chg;
  logic sig_cos;
  logic [7:0] four_ev;
  logic [3:0] summary;

  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign wb = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign mapped = hit(paddr, `OFS_MASK_THREE) || hit(paddr, `OFS_MASK_FOUR) ||
    hit(paddr, `OFS_MASK_HDLC) || hit(paddr, `OFS_MASK_LINK) ||
    hit(paddr, `OFS_SIG_EN_1) || hit(paddr, `OFS_SIG_EN_2) ||
    hit(paddr, `OFS_SIG_EN_3) || hit(paddr, `OFS_SIG_EN_4) ||
    hit(paddr, `OFS_UP_1) || hit(paddr, `OFS_UP_2) || hit(paddr, `OFS_DN_1) ||
    hit(paddr, `OFS_DN_2) || hit(paddr, `OFS_SA_POS_MASK) ||
    hit(paddr, `OFS_STATUS) || hit(paddr, `OFS_CTRL);

  // Unused mask bits read zero; E1 three-register layout only meaningful in E1
  assign three_valid = e1_mode ? `MASK_THREE_E1_BITS : 8'hff;
  assign link_valid = e1_mode ? `MASK_LINK_E1_BITS : `MASK_LINK_T1_BITS;

  // Fourth enable register only watched in E1 mode
  assign sig_cos = |(sig_change & r_r.sig_en &
    {e1_mode ? 8'hff : 8'h00, 24'hffffff});
  assign sa_chg = (sa_bits ^ r_r.sa_prev) & ~r_r.sa_pos_mask;
  always_comb begin
    four_ev = events.four;
    four_ev[`BIT_SIG_CHANGE] = events.four[`BIT_SIG_CHANGE] | sig_cos;
  end

  // Masked sources drop out of the summary, latched bits stay
  assign summary[0] = |(events.three & r_r.mask_three & three_valid);
  assign summary[1] = |(r_r.status_four & r_r.mask_four);
  assign summary[2] = |(events.hdlc & r_r.mask_hdlc);
  assign summary[3] = |({events.link[7:1], events.link[0] | (e1_mode & |sa_chg)}
    & r_r.mask_link & link_valid);

  always_comb begin
    r_nxt = r_r;
    r_nxt.up_restart = 1'b0;
    r_nxt.dn_restart = 1'b0;
    r_nxt.sa_prev = sa_bits;
    // Hardware set wins over a software clear in the same cycle
    if (wr_en && hit(paddr, `OFS_STATUS)) begin
      r_nxt.status_four = r_r.status_four & ~wb;
    end
    r_nxt.status_four = r_nxt.status_four | four_ev;
    if (wr_en) begin
      if (hit(paddr, `OFS_MASK_THREE)) begin
        r_nxt.mask_three = wb;
      end
      if (hit(paddr, `OFS_MASK_FOUR)) begin
        r_nxt.mask_four = wb & `MASK_FOUR_BITS;
      end
      if (hit(paddr, `OFS_MASK_HDLC)) begin
        r_nxt.mask_hdlc = wb & `MASK_HDLC_BITS;
      end
      if (hit(paddr, `OFS_MASK_LINK)) begin
        r_nxt.mask_link = wb & `MASK_LINK_T1_BITS;
      end
      if (hit(paddr, `OFS_SIG_EN_1)) begin
        r_nxt.sig_en[7:0] = wb;
      end
      if (hit(paddr, `OFS_SIG_EN_2)) begin
        r_nxt.sig_en[15:8] = wb;
      end
      if (hit(paddr, `OFS_SIG_EN_3)) begin
        r_nxt.sig_en[23:16] = wb;
      end
      if (hit(paddr, `OFS_SIG_EN_4)) begin
        r_nxt.sig_en[31:24] = wb;
      end
      if (hit(paddr, `OFS_UP_1)) begin
        r_nxt.up_1 = wb;
        r_nxt.up_restart = 1'b1;
      end
      if (hit(paddr, `OFS_UP_2)) begin
        r_nxt.up_2 = wb;
      end
      if (hit(paddr, `OFS_DN_1)) begin
        r_nxt.dn_1 = wb;
        r_nxt.dn_restart = 1'b1;
      end
      if (hit(paddr, `OFS_DN_2)) begin
        r_nxt.dn_2 = wb;
      end
      if (hit(paddr, `OFS_SA_POS_MASK)) begin
        r_nxt.sa_pos_mask = wb;
      end
    end
    r_nxt.prdata = 32'h0;
    if (rd_en) begin
      case (1'b1)
        hit(paddr, `OFS_MASK_THREE): r_nxt.prdata = {24'h0, r_r.mask_three & three_valid};
        hit(paddr, `OFS_MASK_FOUR): r_nxt.prdata = {24'h0, r_r.mask_four};
        hit(paddr, `OFS_MASK_HDLC): r_nxt.prdata = {24'h0, r_r.mask_hdlc};
        hit(paddr, `OFS_MASK_LINK): r_nxt.prdata = {24'h0, r_r.mask_link & link_valid};
        hit(paddr, `OFS_SIG_EN_1): r_nxt.prdata = {24'h0, r_r.sig_en[7:0]};
        hit(paddr, `OFS_SIG_EN_2): r_nxt.prdata = {24'h0, r_r.sig_en[15:8]};
        hit(paddr, `OFS_SIG_EN_3): r_nxt.prdata = {24'h0, r_r.sig_en[23:16]};
        hit(paddr, `OFS_SIG_EN_4): r_nxt.prdata = {24'h0, r_r.sig_en[31:24]};
        hit(paddr, `OFS_UP_1): r_nxt.prdata = {24'h0, r_r.up_1};
        hit(paddr, `OFS_UP_2): r_nxt.prdata = {24'h0, r_r.up_2};
        hit(paddr, `OFS_DN_1): r_nxt.prdata = {24'h0, r_r.dn_1};
        hit(paddr, `OFS_DN_2): r_nxt.prdata = {24'h0, r_r.dn_2};
        hit(paddr, `OFS_SA_POS_MASK): r_nxt.prdata = {24'h0, r_r.sa_pos_mask};
        hit(paddr, `OFS_STATUS): r_nxt.prdata = {24'h0, r_r.status_four};
        hit(paddr, `OFS_CTRL): r_nxt.prdata = {26'h0, up_match, dn_match,
          summary};
        default: r_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Read data is combinational from registers so a zero-wait answer is possible
  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      prdata = r_nxt.prdata;
    end
  end

  // Detector sees only first register; second is don't care for lengths 1..8
  assign up_pattern = r_r.up_1;
  assign dn_pattern = r_r.dn_1;
  assign up_restart = r_r.up_restart;
  assign dn_restart = r_r.dn_restart;
  assign up_code_present = up_match;
  assign down_code_present = dn_match;
  assign latched_status_four = r_r.status_four;
  assign rx_interrupt_source_summary = summary;
  assign rx_int = |summary;
endmodule

//--- rx_event_src.sv
`timescale 1ns/1ps
module rx_event_src (
  // Clock
  input wire logic pclk,
  // Event sources toward the block
  output rx_mask_pkg::events_t events,
  output logic [31:0] sig_change,
  output logic [7:0] sa_bits,
  output logic up_match,
  output logic dn_match
);
  initial begin
    events = '0;
    sig_change = '0;
    sa_bits = 8'h00;
    up_match = 1'b0;
    dn_match = 1'b0;
  end
  // Single-cycle pulses, so each event is seen by exactly one edge
  task automatic pulse(input logic [31:0] ev, input logic [31:0] sc);
    events <= ev;
    sig_change <= sc;
    @(posedge pclk);
    events <= '0;
    sig_change <= '0;
  endtask
endmodule

//--- rx_mask_regs_sva.sv
`timescale 1ns/1ps
`include "rx_mask_params.svh"
module rx_mask_regs_sva (
  // Watched ports
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [13:0] paddr,
  input wire rx_mask_pkg::events_t events,
  input wire logic [31:0] pwdata, prdata, sig_change,
  input wire logic [3:0] pstrb, rx_interrupt_source_summary,
  input wire logic up_match, dn_match, up_restart, up_code_present, down_code_present, rx_int,
  input wire logic [7:0] up_pattern, latched_status_four
);
  localparam logic [13:0] UP_A = {`OFS_UP_1, 2'b00};
  localparam logic [13:0] BAD_A = 14'h0294;
  wire acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_up;
    acc && pwrite && pstrb[0] && paddr == UP_A;
  endsequence
  chk_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  chk_up_restart: assert property (wr_up |=> up_restart) else $error("no restart");
  chk_restart_cause: assert property (up_restart |-> $past(acc && pwrite && paddr == UP_A))
    else $error("stray restart");
  chk_up_pattern: assert property (wr_up |=> up_pattern == $past(pwdata[7:0]))
    else $error("pattern not stored");
  chk_present_flags: assert property (up_code_present == up_match && down_code_present == dn_match)
    else $error("present flag wrong");
  chk_int_summary: assert property (rx_int == |rx_interrupt_source_summary)
    else $error("interrupt not summary OR");
  chk_sig_cause: assert property ($rose(latched_status_four[3]) |->
    $past((|sig_change) || events.four[3]))
    else $error("signaling status without change");
  chk_unmapped_err: assert property (acc && paddr == BAD_A |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  chk_idle_data: assert property (!acc |-> prdata == 32'h0) else $error("prdata outside access");
  chk_masked_start: assert property ($rose(presetn) |-> !rx_int) else $error("unmasked at reset");
endmodule
bind rx_mask_regs rx_mask_regs_sva chk (.*);

//--- rx_interrupt_mask_loop_code_regs_tb_top.sv
`timescale 1ns/1ps
module rx_interrupt_mask_loop_code_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e1_mode, er_v;
  logic up_match, dn_match, up_restart, dn_restart, up_code_present, down_code_present, rx_int;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, sig_change, rd_v;
  logic [3:0] pstrb, rx_interrupt_source_summary;
  logic [7:0] sa_bits, up_pattern, dn_pattern, latched_status_four;
  rx_mask_pkg::events_t events;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] offs [12] = '{8'ha2, 8'ha3, 8'ha4, 8'ha6, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac,
    8'had, 8'hae, 8'haf};
  logic [7:0] t1v [12] = '{8'hff, 8'hef, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff};
  rx_mask_regs dut (.*);
  rx_event_src src (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register index times four is the byte address
  task automatic apb(input logic wr, input logic [7:0] o, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {4'h0, o, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input string w, input logic [7:0] o, input logic [7:0] e, input logic ee);
    apb(1'b0, o, 8'h00);
    check(w, rd_v, {24'h0, e});
    check({w, " err"}, {31'h0, er_v}, {31'h0, ee});
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    e1_mode = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rd("reset", offs[i], 8'h00, 1'b0);
    foreach (offs[i]) apb(1'b1, offs[i], 8'hff);
    foreach (offs[i]) rd("t1 mask", offs[i], t1v[i], 1'b0);
    e1_mode <= 1'b1;
    rd("e1 three", 8'ha2, 8'h3b, 1'b0);
    rd("e1 seven", 8'ha6, 8'h03, 1'b0);
    rd("unmapped", 8'ha5, 8'h00, 1'b1);
    e1_mode <= 1'b0;
    apb(1'b1, 8'ha3, 8'h00);
    src.pulse(32'h0080_0000, 32'h0);
    @(posedge pclk);
    check("masked latch", {24'h0, latched_status_four}, 32'h80);
    check("masked irq", {31'h0, rx_int}, 32'h0);
    apb(1'b1, 8'ha3, 8'h80);
    check("unmasked irq", {31'h0, rx_int}, 32'h1);
    apb(1'b1, 8'hbd, 8'h80);
    apb(1'b1, 8'ha8, 8'h01);
    src.pulse(32'h0, 32'h2);
    @(posedge pclk);
    check("ch2 off", {24'h0, latched_status_four}, 32'h0);
    src.pulse(32'h0, 32'h1);
    @(posedge pclk);
    check("ch1 on", {24'h0, latched_status_four}, 32'h08);
    apb(1'b1, 8'hbd, 8'hff);
    src.pulse(32'h0, 32'h0100_0000);
    @(posedge pclk);
    check("ch25 t1", {24'h0, latched_status_four}, 32'h0);
    e1_mode <= 1'b1;
    src.pulse(32'h0, 32'h0100_0000);
    @(posedge pclk);
    check("ch25 e1", {24'h0, latched_status_four}, 32'h08);
    apb(1'b1, 8'hbc, 8'hff);
    src.sa_bits <= 8'h01;
    @(negedge pclk);
    check("sa masked", {31'h0, rx_int}, 32'h0);
    @(posedge pclk);
    apb(1'b1, 8'hbc, 8'h00);
    src.sa_bits <= 8'h03;
    @(negedge pclk);
    check("sa change", {31'h0, rx_int}, 32'h1);
    @(posedge pclk);
    e1_mode <= 1'b0;
    src.up_match <= 1'b1;
    apb(1'b1, 8'hac, 8'h80);
    check("up flag", {31'h0, up_code_present}, 32'h1);
    check("up pattern", {24'h0, up_pattern}, 32'h80);
    tally_and_finish();
  end
endmodule
